// ### rtl/wdt_map.svh
// Register offsets, field positions, reset values and timing counts
`ifndef WDT_MAP_SVH
`define WDT_MAP_SVH
`define WDT_CTRL_OFS      8'h00
`define WDT_RCF_OFS       8'h04
`define WDT_WAKEEN_OFS    8'h08
`define WDT_STAT_OFS      8'h0c
`define WDT_CMD_OFS       8'h10
`define WDT_CTRL_RST      8'h53
`define WDT_KEY_MSB       7
`define WDT_KEY_LSB       3
`define WDT_PS_MSB        2
`define WDT_PS_LSB        0
`define WDT_KEY_OFF       5'h15
`define WDT_KEY_ON        5'h0a
`define WDT_SRF_BIT       0
`define WDT_LVF_BIT       2
`define WDT_PS_BASE       8
`define WDT_SRST_DLY      4
`define WDT_CORE_MHZ      50
`define WDT_SLOW_KHZ      32
`define WDT_SLOW_DIV      ((`WDT_CORE_MHZ * 1000) / `WDT_SLOW_KHZ)
`endif

// ### rtl/wdt_pkg.sv
// Types shared by the watchdog and wake-up block
package wdt_pkg;
    typedef enum logic [1:0] {
        MODE_SLEEP = 2'b00,
        MODE_IDLE0 = 2'b01,
        MODE_IDLE_FAST = 2'b10,
        MODE_IDLE_BOTH = 2'b11
    } halt_mode_e;
    typedef enum logic [1:0] {
        ST_RUN   = 2'b00,
        ST_HALT  = 2'b01,
        ST_SRST  = 2'b10
    } pwr_state_e;
    typedef struct packed {
        logic clearWatchdog;
        logic halt;
    } cpu_cmd_s;
    typedef struct packed {
        logic fullReset;
        logic pcSpReset;
        logic wake;
        logic resumeNext;
        logic intEntry;
    } core_ctl_s;
endpackage

// ### rtl/slow_tick_gen.sv
// Slow oscillator tick generator derived from the core clock
`timescale 1ns/10ps
`default_nettype none
`include "wdt_map.svh"
module slow_tick_gen #(
    parameter int DIV = `WDT_SLOW_DIV
) (
    input  wire logic core_clk,   // Core clock
    input  wire logic sys_rst,    // Sync reset
    input  wire logic clkEn,      // Clock enable
    output logic      tick        // One pulse per slow period
);
    logic [15:0] count;

    // Free running divider; stays running in every low-power mode
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            count <= 16'h0000;
        else if (clkEn)
            count <= (count == 16'(DIV - 1)) ? 16'h0000 : count + 16'h0001;
    end

    assign tick = clkEn && (count == 16'(DIV - 1));
endmodule
`default_nettype wire

// ### rtl/wdt_counter.sv
// Watchdog counter with power-of-two overflow select
`timescale 1ns/10ps
`default_nettype none
`include "wdt_map.svh"
module wdt_counter (
    input  wire logic       core_clk,  // Core clock
    input  wire logic       sys_rst,   // Sync reset
    input  wire logic       clkEn,     // Clock enable
    input  wire logic       tick,      // Slow clock tick
    input  wire logic       run,       // Watchdog enabled
    input  wire logic       clear,     // Clear request
    input  wire logic [2:0] periodSel, // Period select
    output logic            overflow   // One-cycle overflow
);
    logic [15:0] count;
    logic [15:0] limit;

    assign limit = 16'(16'h0001 << (`WDT_PS_BASE + 32'(periodSel)));

    // Clear wins over counting so a cleared timer never fires late
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            count <= 16'h0000;
        else if (clkEn)
        begin
            if (clear || overflow)
                count <= 16'h0000;
            else if (run && tick)
                count <= count + 16'h0001;
        end
    end

    // Pulse when the selected count is reached
    assign overflow = clkEn && run && !clear && (count >= limit);
endmodule
`default_nettype wire

// ### rtl/watchdog_wakeup.sv
// Watchdog timer, software-reset key check and halt/wake-up control
`timescale 1ns/10ps
`default_nettype none
`include "wdt_map.svh"
module watchdog_and_wakeup_logic #(
    parameter int PORTA_W   = 8,
    parameter int IRQ_W     = 8,
    parameter int SRST_DLY  = `WDT_SRST_DLY,
    parameter int SLOW_DIV  = `WDT_SLOW_DIV
) (
    input  wire logic               core_clk,  // Core clock
    input  wire logic               sys_rst,   // Power-on reset, sync
    input  wire logic               clkEn,     // Freezes state when low
    input  wire logic [7:0]         adr_i,     // Wishbone byte address
    input  wire logic [31:0]        dat_i,     // Wishbone write data
    output logic      [31:0]        dat_o,     // Wishbone read data
    input  wire logic               cyc_i,     // Wishbone cycle
    input  wire logic               stb_i,     // Wishbone strobe
    input  wire logic               we_i,      // Wishbone write enable
    input  wire logic [3:0]         sel_i,     // Wishbone byte select
    output logic                    ack_o,     // Wishbone acknowledge
    output logic                    err_o,     // Unmapped address
    input  wire wdt_pkg::cpu_cmd_s  cpuCmd,    // Instruction strobes
    input  wire logic               keepFast,  // Keep fast osc in halt
    input  wire logic               keepSlow,  // Keep slow osc in halt
    input  wire logic               lowVoltEvt,// Low-voltage event pulse
    input  wire logic [PORTA_W-1:0] portA,     // Port A pin levels
    input  wire logic [IRQ_W-1:0]   irqReq,    // Interrupt request flags
    input  wire logic [IRQ_W-1:0]   irqEn,     // Interrupt enables
    input  wire logic               stackFull, // Stack has no room
    output wdt_pkg::core_ctl_s      coreCtl,   // Reset and wake controls
    output logic                    expiryFlag,    // Time-out status
    output logic                    powerdownFlag, // Powerdown status
    output wdt_pkg::halt_mode_e     haltMode,  // Current low-power mode
    output logic                    halted     // In sleep or idle
);
    // ********************************************************
    // Registers and state
    // ********************************************************
    logic [7:0]           watchdog_control;
    logic                 softResetCauseFlag;
    logic                 lowVoltageCauseFlag;
    logic [PORTA_W-1:0]   portAWakeEnable;
    logic [PORTA_W-1:0]   portAPrev;
    logic [IRQ_W-1:0]     irqMask;
    wdt_pkg::pwr_state_e  state;
    logic [7:0]           srstCount;
    logic                 tick;
    logic                 overflow;
    logic                 wdtRun;
    logic                 wdtClear;
    logic                 keyBad;
    logic                 busHit;
    logic                 wrCtrl;
    logic                 wrRcf;
    logic                 wrWake;
    logic [4:0]           key;
    logic                 pinWake;
    logic [IRQ_W-1:0]     irqWakeVec;
    logic                 irqWake;
    logic                 irqServ;
    logic                 mapped;

    assign key    = watchdog_control[`WDT_KEY_MSB:`WDT_KEY_LSB];
    assign keyBad = (key != `WDT_KEY_ON) && (key != `WDT_KEY_OFF);
    assign wdtRun = (key == `WDT_KEY_ON) && (state != wdt_pkg::ST_SRST);

    // ********************************************************
    // Wishbone slave
    // ********************************************************
    assign busHit = cyc_i && stb_i && !ack_o && !err_o;
    assign mapped = (adr_i == `WDT_CTRL_OFS) || (adr_i == `WDT_RCF_OFS)
                 || (adr_i == `WDT_WAKEEN_OFS) || (adr_i == `WDT_STAT_OFS)
                 || (adr_i == `WDT_CMD_OFS);
    assign wrCtrl = clkEn && busHit && we_i && sel_i[0]
                 && (adr_i == `WDT_CTRL_OFS);
    assign wrRcf  = clkEn && busHit && we_i && sel_i[0]
                 && (adr_i == `WDT_RCF_OFS);
    assign wrWake = clkEn && busHit && we_i && sel_i[0]
                 && (adr_i == `WDT_WAKEEN_OFS);

    // One-cycle ack after request, dropped the cycle after
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            ack_o <= 1'b0;
            err_o <= 1'b0;
        end
        else if (clkEn)
        begin
            ack_o <= busHit && mapped;
            err_o <= busHit && !mapped;
        end
    end

    // Read data registered at the accepting edge
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            dat_o <= 32'h0000_0000;
        else if (clkEn && busHit)
        begin
            unique case (adr_i)
                `WDT_CTRL_OFS:   dat_o <= {24'h000000, watchdog_control};
                `WDT_RCF_OFS:    dat_o <= {29'h0, lowVoltageCauseFlag,
                                           1'b0, softResetCauseFlag};
                `WDT_WAKEEN_OFS: dat_o <= 32'(portAWakeEnable);
                `WDT_STAT_OFS:   dat_o <= {28'h0, halted, wdtRun,
                                           powerdownFlag, expiryFlag};
                default:         dat_o <= 32'h0000_0000;
            endcase
        end
    end

    // ********************************************************
    // Watchdog control register
    // ********************************************************
    // Power-on value runs watchdog with period code 011
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            watchdog_control <= `WDT_CTRL_RST;
        else if (wrCtrl)
            watchdog_control <= dat_i[7:0];
    end

    // Wake enables kept across a watchdog wake, cleared at power-on
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            portAWakeEnable <= '0;
        else if (wrWake)
            portAWakeEnable <= dat_i[PORTA_W-1:0];
    end

    // Cause flags survive soft and watchdog resets; cleared by power-on reset or the flag's own clear
    // Set beats software clear so an event is never lost
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            softResetCauseFlag  <= 1'b0;
            lowVoltageCauseFlag <= 1'b0;
        end
        else if (clkEn)
        begin
            if (state == wdt_pkg::ST_SRST && coreCtl.fullReset)
                softResetCauseFlag <= 1'b1;
            else if (wrRcf && !dat_i[`WDT_SRF_BIT])
                softResetCauseFlag <= 1'b0;
            if (lowVoltEvt)
                lowVoltageCauseFlag <= 1'b1;
            else if (wrRcf && !dat_i[`WDT_LVF_BIT])
                lowVoltageCauseFlag <= 1'b0;
        end
    end

    // ********************************************************
    // Watchdog counter
    // ********************************************************
    slow_tick_gen #(
        .DIV      (SLOW_DIV)
    ) u_tick (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .clkEn    (clkEn),
        .tick     (tick)
    );

    // These three events clear the timer, besides its own overflow
    assign wdtClear = (cpuCmd.clearWatchdog && state == wdt_pkg::ST_RUN)
                   || (cpuCmd.halt && state == wdt_pkg::ST_RUN)
                   || (keyBad && state != wdt_pkg::ST_SRST);

    wdt_counter u_cnt (
        .core_clk  (core_clk),
        .sys_rst   (sys_rst),
        .clkEn     (clkEn),
        .tick      (tick),
        .run       (wdtRun),
        .clear     (wdtClear),
        .periodSel (watchdog_control[`WDT_PS_MSB:`WDT_PS_LSB]),
        .overflow  (overflow)
    );

    // ********************************************************
    // Wake sources
    // ********************************************************
    // Falling edge on an enabled Port A pin
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            portAPrev <= '1;
        else if (clkEn)
            portAPrev <= portA;
    end
    assign pinWake = |(portAPrev & ~portA & portAWakeEnable);

    // Requests already pending at halt are masked off
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            irqMask <= '0;
        else if (clkEn && cpuCmd.halt && state == wdt_pkg::ST_RUN)
            irqMask <= irqReq;
    end
    assign irqWakeVec = irqReq & ~irqMask;
    assign irqWake    = |irqWakeVec;
    // Enabled with stack room enters the handler; else resume, stay pending
    assign irqServ    = |(irqWakeVec & irqEn) && !stackFull;

    // ********************************************************
    // Power state machine
    // ********************************************************
    // Bad key waits a fixed slow-tick delay before the full reset
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            state     <= wdt_pkg::ST_RUN;
            srstCount <= 8'h00;
            haltMode  <= wdt_pkg::MODE_SLEEP;
        end
        else if (clkEn)
        begin
            unique case (state)
                wdt_pkg::ST_RUN:
                begin
                    srstCount <= 8'h00;
                    if (keyBad)
                        state <= wdt_pkg::ST_SRST;
                    else if (cpuCmd.halt)
                    begin
                        state    <= wdt_pkg::ST_HALT;
                        haltMode <= wdt_pkg::halt_mode_e'({keepFast,
                                                           keepSlow});
                    end
                end
                wdt_pkg::ST_HALT:
                begin
                    if (keyBad)
                        state <= wdt_pkg::ST_SRST;
                    else if (overflow || pinWake || irqWake)
                        state <= wdt_pkg::ST_RUN;
                end
                wdt_pkg::ST_SRST:
                begin
                    if (coreCtl.fullReset)
                    begin
                        state     <= wdt_pkg::ST_RUN;
                        srstCount <= 8'h00;
                    end
                    else if (tick)
                        srstCount <= srstCount + 8'h01;
                end
                default:
                    state <= wdt_pkg::ST_RUN;
            endcase
        end
    end

    // Bad key stays once the delay fires: control is not reset, so ST_SRST is re-entered
    assign halted = (state == wdt_pkg::ST_HALT);

    // Reset and wake outputs toward the core
    always_comb
    begin
        coreCtl = '0;
        if (clkEn)
        begin
            coreCtl.fullReset = (state == wdt_pkg::ST_SRST
                                 && srstCount == 8'(SRST_DLY))
                             || (state == wdt_pkg::ST_RUN && overflow
                                 && !keyBad);
            coreCtl.wake      = halted && !keyBad
                             && (overflow || pinWake || irqWake);
            coreCtl.pcSpReset = halted && !keyBad && overflow;
            coreCtl.intEntry  = coreCtl.wake && !overflow && !pinWake
                             && irqServ;
            coreCtl.resumeNext = coreCtl.wake && !overflow
                              && !coreCtl.intEntry;
        end
    end

    // ********************************************************
    // Status flags
    // ********************************************************
    // Expiry flag: set by overflow, cleared by halt and clear instruction
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            expiryFlag <= 1'b0;
        else if (clkEn)
        begin
            if (overflow && state != wdt_pkg::ST_SRST)
                expiryFlag <= 1'b1;
            else if ((cpuCmd.halt || cpuCmd.clearWatchdog)
                     && state == wdt_pkg::ST_RUN)
                expiryFlag <= 1'b0;
        end
    end

    // Powerdown flag: set by halt, cleared by clear instruction
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            powerdownFlag <= 1'b0;
        else if (clkEn && state == wdt_pkg::ST_RUN)
        begin
            if (cpuCmd.halt)
                powerdownFlag <= 1'b1;
            else if (cpuCmd.clearWatchdog)
                powerdownFlag <= 1'b0;
        end
    end

    // ********************************************************
    // Checks
    // ********************************************************
    a_halt_sets_pd: assert property (@(posedge core_clk) disable iff (sys_rst)
        clkEn && cpuCmd.halt && state == wdt_pkg::ST_RUN && !keyBad
        |=> powerdownFlag && !expiryFlag && halted)
        else $error("halt did not set powerdown");
    a_clr_pd: assert property (@(posedge core_clk) disable iff (sys_rst)
        clkEn && cpuCmd.clearWatchdog && !cpuCmd.halt
        && state == wdt_pkg::ST_RUN |=> !powerdownFlag)
        else $error("clear did not drop powerdown");
    a_run_overflow: assert property (@(posedge core_clk) disable iff (sys_rst)
        overflow && state == wdt_pkg::ST_RUN && !keyBad
        |-> coreCtl.fullReset ##1 expiryFlag)
        else $error("overflow gave no reset");
    a_halt_overflow: assert property (@(posedge core_clk) disable iff (sys_rst)
        overflow && halted && !keyBad
        |-> coreCtl.pcSpReset && coreCtl.wake && !coreCtl.fullReset
            ##1 expiryFlag && !halted)
        else $error("halt overflow wrong");
    a_bad_key_go: assert property (@(posedge core_clk) disable iff (sys_rst)
        clkEn && keyBad && state == wdt_pkg::ST_RUN
        |=> state == wdt_pkg::ST_SRST)
        else $error("bad key not seen");
    a_srst_flag: assert property (@(posedge core_clk) disable iff (sys_rst)
        coreCtl.fullReset && state == wdt_pkg::ST_SRST
        |=> softResetCauseFlag)
        else $error("soft reset flag not set");
    a_off_key_quiet: assert property (@(posedge core_clk) disable iff (sys_rst)
        key == `WDT_KEY_OFF |-> !overflow)
        else $error("disabled watchdog fired");
    a_pin_wake: assert property (@(posedge core_clk) disable iff (sys_rst)
        halted && pinWake && !overflow && !keyBad
        |-> coreCtl.resumeNext || coreCtl.intEntry)
        else $error("pin wake lost");
    a_no_over_clr: assert property (@(posedge core_clk) disable iff (sys_rst)
        wdtClear |-> !overflow)
        else $error("overflow with clear");
endmodule
`default_nettype wire

// ### testbench/tb_watchdog_and_wakeup_logic.sv
// Self-checking bench for the watchdog and wake-up block
`timescale 1ns/10ps
`default_nettype none
module tb_watchdog_and_wakeup_logic;
    // ****************************************
    // Signals, table and instance
    // ****************************************
    typedef struct packed {logic [7:0] a; logic [31:0] d, x; logic er;} row_s;
    logic                core_clk, sys_rst, cyc, stb, we, ack, err, e;
    logic                keepFast, keepSlow, lowVoltEvt, stackFull, clkEn;
    logic [7:0]          adr, portA, irqReq, irqEn;
    logic [31:0]         datI, datO, q;
    wdt_pkg::cpu_cmd_s   cpuCmd;
    wdt_pkg::core_ctl_s  coreCtl;
    wdt_pkg::halt_mode_e haltMode;
    logic                expiryFlag, powerdownFlag, halted;
    int                  nMismatch, nTests, n, i, c;
    row_s                rows [5] = '{'{8'h00, 32'ha8, 32'ha8, 1'b0},
        '{8'h00, 32'haf, 32'haf, 1'b0}, '{8'h08, 32'h5a, 32'h5a, 1'b0},
        '{8'h10, 32'hff, 32'h00, 1'b0}, '{8'h20, 32'hff, 32'h00, 1'b1}};

    // Slow divider shrunk to 4 so a 2^8 period is about 1024 cycles
    watchdog_and_wakeup_logic #(.SLOW_DIV(4)) i_watchdog_and_wakeup_logic (
        .core_clk(core_clk), .sys_rst(sys_rst), .clkEn(clkEn), .adr_i(adr),
        .dat_i(datI), .dat_o(datO), .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .sel_i(4'h1), .ack_o(ack), .err_o(err), .cpuCmd(cpuCmd),
        .keepFast(keepFast), .keepSlow(keepSlow), .lowVoltEvt(lowVoltEvt),
        .portA(portA), .irqReq(irqReq), .irqEn(irqEn), .stackFull(stackFull),
        .coreCtl(coreCtl), .expiryFlag(expiryFlag),
        .powerdownFlag(powerdownFlag), .haltMode(haltMode), .halted(halted));

    // 50 MHz core clock
    initial
    begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        nTests++;
        if (got !== exp)
        begin
            nMismatch++;
            $display("ERROR %0t: saw %h wanted %h", $time, got, exp);
        end
    endtask

    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", nTests, nMismatch);
        if (nMismatch == 0 && nTests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Classic single cycle; request held until ack or err is sampled
    task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int k;
        @(posedge core_clk);
        adr <= a; we <= w; datI <= d; cyc <= 1'b1; stb <= 1'b1;
        for (k = 0; k < 50; k++)
        begin
            @(posedge core_clk);
            if (ack === 1'b1 || err === 1'b1)
                break;
        end
        q = datO;
        e = err;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
        if (k == 50)
        begin
            nMismatch++;
            close_out();
        end
    endtask

    // One-cycle instruction strobe; returns once its effect has landed
    task automatic cmd(input logic clr);
        @(posedge core_clk);
        if (clr) cpuCmd.clearWatchdog <= 1'b1;
        else cpuCmd.halt <= 1'b1;
        @(posedge core_clk);
        cpuCmd <= 2'b00;
        @(posedge core_clk);
    endtask

    // Bounded wait for full reset (0) or wake (1); n == lim means none came
    task automatic waitEv(input int which, input int lim);
        for (n = 0; n < lim; n++)
        begin
            @(posedge core_clk);
            if ((which == 0 ? coreCtl.fullReset : coreCtl.wake) === 1'b1)
                break;
        end
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        sys_rst = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00;
        datI = 32'h0; cpuCmd = 2'b00; keepFast = 1'b1; keepSlow = 1'b0;
        lowVoltEvt = 1'b0; stackFull = 1'b0; portA = 8'hff;
        irqReq = 8'h00; irqEn = 8'h00; nMismatch = 0; nTests = 0;
        clkEn = 1'b1;
        repeat (16) @(posedge core_clk);
        sys_rst <= 1'b0;
        wb(8'h00, 1'b0, 32'h0); chk(q, 32'h53);
        wb(8'h04, 1'b0, 32'h0); chk(q, 32'h00);
        chk({expiryFlag, powerdownFlag}, 32'h0);
        $display("reset values done");
        // Register rows: write, read back, unmapped gives err
        for (i = 0; i < 5; i++)
        begin
            wb(rows[i].a, 1'b1, rows[i].d);
            wb(rows[i].a, 1'b0, 32'h0);
            chk(e, rows[i].er);
            if (!rows[i].er) chk(q, rows[i].x);
        end
        $display("register rows done");
        // Disabled key: no overflow over more than one short period
        waitEv(0, 1200); chk(n, 1200);
        // Enabled key: period scales by two per code step
        for (c = 0; c < 2; c++)
        begin
            wb(8'h00, 1'b1, 32'h50 | c);
            cmd(1'b1);
            waitEv(0, 3000);
            chk(n >= (1024 << c) - 8 && n <= (1024 << c) + 8, 1);
            chk(coreCtl.wake, 1'b0);
            @(posedge core_clk); chk(expiryFlag, 1'b1);
        end
        $display("overflow periods done");
        // Halt, then wake on an enabled Port A falling edge
        wb(8'h08, 1'b1, 32'h01);
        cmd(1'b0);
        chk({halted, powerdownFlag, expiryFlag}, 32'h6);
        chk(32'(haltMode), 32'h2);
        portA <= 8'hfe;
        waitEv(1, 20); chk(n < 20, 1); chk(coreCtl.resumeNext, 1'b1);
        @(posedge core_clk); chk(halted, 1'b0);
        portA <= 8'hff;
        // Interrupt wake: disabled resumes, enabled enters the handler
        for (c = 0; c < 2; c++)
        begin
            irqEn <= 8'(c);
            cmd(1'b0);
            irqReq <= 8'h01;
            waitEv(1, 20); chk(n < 20, 1);
            chk({coreCtl.intEntry, coreCtl.resumeNext}, c ? 2 : 1);
            irqReq <= 8'h00;
        end
        // Request already pending at halt cannot wake; overflow does
        irqReq <= 8'h02; irqEn <= 8'h02; keepFast <= 1'b0;
        cmd(1'b0); chk(32'(haltMode), 32'h0);
        waitEv(1, 3000); chk(n > 1000 && n < 3000, 1);
        chk({coreCtl.pcSpReset, coreCtl.fullReset}, 32'h2);
        @(posedge core_clk); chk({expiryFlag, powerdownFlag}, 32'h3);
        irqReq <= 8'h00;
        cmd(1'b1); chk(powerdownFlag, 1'b0);
        $display("halt and wake done");
        // Low-voltage cause flag, then a bad key gives a delayed reset
        @(posedge core_clk); lowVoltEvt <= 1'b1;
        @(posedge core_clk); lowVoltEvt <= 1'b0;
        wb(8'h00, 1'b1, 32'h00);
        waitEv(0, 200); chk(n >= 8 && n < 40, 1);
        wb(8'h04, 1'b0, 32'h0); chk(q, 32'h05);
        // Good key first: a bad key left in place keeps re-firing resets
        wb(8'h00, 1'b1, 32'ha8);
        repeat (40) @(posedge core_clk);
        wb(8'h04, 1'b1, 32'h00);
        wb(8'h04, 1'b0, 32'h0); chk(q, 32'h00);
        $display("soft reset done");
        // Clock enable low: a halt strobe must be ignored
        clkEn <= 1'b0;
        cmd(1'b0); chk(halted, 1'b0);
        clkEn <= 1'b1;
        $display("clock enable done");
        close_out();
    end
endmodule
`default_nettype wire
